// file: tmds_pkg.sv
// Shared constants, register map and date types of the twelve-month switch.
// Assumes a binary calendar date from an external real-time clock source.
package tmds_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets (byte addresses, one word each)
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ON_DATE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_OFF_DATE = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_CAL_DATE = 8'h10;

  // Status bit positions
  localparam int ST_OUT_BIT = 0;
  localparam int ST_REJECT_BIT = 1;
  localparam int ST_FIRED_BIT = 2;

  // Date word layout: year high, then month, then day
  localparam int DAY_LSB = 0;
  localparam int DAY_W = 5;
  localparam int MON_LSB = 8;
  localparam int MON_W = 4;
  localparam int YEAR_LSB = 16;
  localparam int YEAR_W = 12;

  // Accepted calendar span, full binary years
  localparam logic [YEAR_W-1:0] YEAR_MIN = 12'h7d0;
  localparam logic [YEAR_W-1:0] YEAR_MAX = 12'h833;
  localparam logic [MON_W-1:0] MON_MAX = 4'hc;

  // Field order makes a packed compare a chronological compare
  typedef struct packed {
    logic [YEAR_W-1:0] year;
    logic [MON_W-1:0] month;
    logic [DAY_W-1:0] day;
  } tmds_date_t;

  typedef struct packed {
    logic pulse;
    logic yearly;
    logic monthly;
    logic enable;
  } tmds_ctrl_t;

  typedef enum logic [1:0] {MODE_SPAN, MODE_MONTHLY, MODE_YEARLY} tmds_mode_t;

  // Reset values
  localparam tmds_ctrl_t CTRL_RESET = 4'h0;
  localparam tmds_date_t ON_RESET = {12'h7d0, 4'h1, 5'h01};
  localparam tmds_date_t OFF_RESET = {12'h833, 4'hc, 5'h1f};

  function automatic tmds_date_t unpack_date(input logic [DATA_W-1:0] w);
    return {w[YEAR_LSB +: YEAR_W], w[MON_LSB +: MON_W], w[DAY_LSB +: DAY_W]};
  endfunction : unpack_date

  function automatic logic [DATA_W-1:0] pack_date(input tmds_date_t d);
    logic [DATA_W-1:0] w;
    w = '0;
    w[YEAR_LSB +: YEAR_W] = d.year;
    w[MON_LSB +: MON_W] = d.month;
    w[DAY_LSB +: DAY_W] = d.day;
    return w;
  endfunction : pack_date

  function automatic logic date_in_range(input tmds_date_t d);
    return d.year >= YEAR_MIN && d.year <= YEAR_MAX && d.month <= MON_MAX;
  endfunction : date_in_range

  function automatic logic [MON_W+DAY_W-1:0] md_key(input tmds_date_t d);
    return {d.month, d.day};
  endfunction : md_key

endpackage : tmds_pkg

// file: tmds_date_reg.sv
// One on- or off-date setting with range check on write.
// Assumes writes come as single-cycle strobes from the register decode.
`timescale 1ns/1ps
module tmds_date_reg import tmds_pkg::*; #(
  parameter tmds_date_t RESET_DATE = ON_RESET
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Write side
  input wire logic wr_en,
  input wire logic [DATA_W-1:0] wr_data,
  // Stored setting
  output tmds_date_t date,
  output logic rejected
);

  tmds_date_t cand;
  logic ok;

  assign cand = unpack_date(wr_data);
  assign ok = date_in_range(cand);

  // Out-of-span writes leave the old date in place
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      date <= RESET_DATE;
    end else if (wr_en && ok) begin
      date <= cand;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rejected <= 1'b0;
    end else begin
      rejected <= wr_en && !ok;
    end
  end

  a_span_held: assert property (@(posedge ref_clk) disable iff (reset)
    date_in_range(date))
    else $error("stored date outside accepted span");

  a_field_order: assert property (@(posedge ref_clk) disable iff (reset)
    wr_en && ok |=> date.year == $past(wr_data[YEAR_LSB +: YEAR_W])
      && date.month == $past(wr_data[MON_LSB +: MON_W])
      && date.day == $past(wr_data[DAY_LSB +: DAY_W]))
    else $error("date fields not taken in year-month-day order");

endmodule : tmds_date_reg

// file: tmds_window.sv
// Combinational date window: level and pulse match for the selected mode.
// Assumes the current date and both settings are stable within a cycle.
`timescale 1ns/1ps
module tmds_window import tmds_pkg::*; (
  // Dates
  input tmds_date_t cur,
  input tmds_date_t on_d,
  input tmds_date_t off_d,
  // Mode
  input tmds_mode_t mode,
  // Results
  output logic level_hit,
  output logic pulse_hit
);

  logic in_years;

  always_comb begin
    in_years = cur.year >= on_d.year && cur.year <= off_d.year;
    level_hit = 1'b0;
    pulse_hit = 1'b0;
    unique case (mode)
      MODE_MONTHLY: begin
        pulse_hit = in_years && cur.day == on_d.day;
        if (on_d.day <= off_d.day) begin
          level_hit = in_years && cur.day >= on_d.day && cur.day < off_d.day;
        end else begin
          level_hit = in_years && (cur.day >= on_d.day || cur.day < off_d.day);
        end
      end
      MODE_YEARLY: begin
        // Both the on year and the off year limit a yearly pulse
        pulse_hit = in_years && md_key(cur) == md_key(on_d);
        if (md_key(on_d) <= md_key(off_d)) begin
          level_hit = in_years && md_key(cur) >= md_key(on_d)
            && md_key(cur) < md_key(off_d);
        end else begin
          // Wrapping window: head needs a year before the off year, tail a year after the on year
          level_hit = (md_key(cur) >= md_key(on_d) && cur.year >= on_d.year
            && cur.year < off_d.year)
            || (md_key(cur) < md_key(off_d) && cur.year > on_d.year
            && cur.year <= off_d.year);
        end
      end
      MODE_SPAN: begin
        pulse_hit = cur == on_d;
        level_hit = cur >= on_d && cur < off_d;
      end
    endcase
  end

endmodule : tmds_window

// file: tmds_switch.sv
// Top of the twelve-month date switch: registers, scan evaluation, output.
// Assumes a one-cycle scan_tick per program cycle and a calendar date
// that is synchronous to ref_clk and changes at 00:00.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps

// Operation
// - Output rises only at a day boundary or after a settings rewrite
// - Dates accepted only from 2000 to 2099
// - Date fields ordered year, month, day
// - Monthly: on at on-day, off at off-day
// - Yearly: on at on-date, off at off-date
// - On year first, off year last
// - Pulse lasts exactly one scan cycle
// - Pulse combines with monthly, yearly or neither
// - No mode: hold on from on to off
// - Yearly wrap spans new year, stops after end
// - Yearly pulse each year, off year limits
// - Single pulse fires once only
// - Monthly repeats through last month of final year
module tmds_switch import tmds_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Scan cycle enable and calendar
  input wire logic scan_tick,
  input tmds_date_t cal_date,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Switch output
  output logic switch_out
);

  tmds_ctrl_t ctrl;
  tmds_date_t on_date;
  tmds_date_t off_date;
  tmds_date_t last_date;
  tmds_mode_t mode;
  logic wr_ctrl;
  logic wr_on;
  logic wr_off;
  logic wr_status;
  logic on_rej;
  logic off_rej;
  logic reject_flag;
  logic pending_eval;
  logic seen;
  logic fired;
  logic level_hit;
  logic pulse_hit;
  logic date_changed;
  logic day_edge;
  logic single_pulse;
  logic next_out;
  logic settings_wr;
  logic [DATA_W-1:0] status_word;

  // Same decode for every write strobe, so all write enables agree on the map
  function automatic logic strobe_hit(input logic strobe, input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offs);
    return strobe && addr == offs;
  endfunction : strobe_hit

  // Register decode
  assign wr_ctrl = strobe_hit(reg_wr, reg_addr, REG_CTRL);
  assign wr_on = strobe_hit(reg_wr, reg_addr, REG_ON_DATE);
  assign wr_off = strobe_hit(reg_wr, reg_addr, REG_OFF_DATE);
  assign wr_status = strobe_hit(reg_wr, reg_addr, REG_STATUS);
  // Any setting write, rejected or not, re-arms the evaluation
  assign settings_wr = wr_ctrl || wr_on || wr_off;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= reg_wdata[$bits(tmds_ctrl_t)-1:0];
    end
  end

  tmds_date_reg #(
    .RESET_DATE(ON_RESET)
  ) u_on_date (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_en(wr_on),
    .wr_data(reg_wdata),
    .date(on_date),
    .rejected(on_rej)
  );

  tmds_date_reg #(
    .RESET_DATE(OFF_RESET)
  ) u_off_date (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_en(wr_off),
    .wr_data(reg_wdata),
    .date(off_date),
    .rejected(off_rej)
  );

  // Sticky reject flag; a new reject wins over a software clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reject_flag <= 1'b0;
    end else if (on_rej || off_rej) begin
      reject_flag <= 1'b1;
    end else if (wr_status && reg_wdata[ST_REJECT_BIT]) begin
      reject_flag <= 1'b0;
    end
  end

  // Monthly takes precedence when both repeat modes are set
  assign mode = ctrl.monthly ? MODE_MONTHLY : (ctrl.yearly ? MODE_YEARLY : MODE_SPAN);

  tmds_window u_window (
    .cur(cal_date),
    .on_d(on_date),
    .off_d(off_date),
    .mode(mode),
    .level_hit(level_hit),
    .pulse_hit(pulse_hit)
  );

  // A settings change forces a fresh evaluation at the next scan
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pending_eval <= 1'b1;
    end else if (settings_wr) begin
      pending_eval <= 1'b1;
    end else if (scan_tick) begin
      pending_eval <= 1'b0;
    end
  end

  // Date of the last evaluation, so a new day is seen once
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      last_date <= ON_RESET;
      seen <= 1'b0;
    end else if (scan_tick) begin
      last_date <= cal_date;
      seen <= 1'b1;
    end
  end

  // The first scan after reset has no day to compare with; only pending counts
  assign date_changed = scan_tick && seen && cal_date != last_date;
  assign day_edge = date_changed || (scan_tick && pending_eval);
  assign single_pulse = ctrl.pulse && mode == MODE_SPAN;

  // Single pulse is spent until the settings are rewritten
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fired <= 1'b0;
    end else if (ctrl.enable && single_pulse && date_changed && pulse_hit) begin
      fired <= 1'b1;
    end else if (settings_wr) begin
      fired <= 1'b0;
    end
  end

  // Pulses only on a real date change, so a rewrite never pulses mid-day
  always_comb begin
    next_out = switch_out;
    if (!ctrl.enable) begin
      next_out = 1'b0;
    end else if (scan_tick) begin
      if (ctrl.pulse) begin
        next_out = date_changed && pulse_hit && !(single_pulse && fired);
      end else if (day_edge) begin
        next_out = level_hit;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      switch_out <= 1'b0;
    end else begin
      switch_out <= next_out;
    end
  end

  // Status bits placed by name, so the map lives in one spot
  always_comb begin
    status_word = '0;
    status_word[ST_OUT_BIT] = switch_out;
    status_word[ST_REJECT_BIT] = reject_flag;
    status_word[ST_FIRED_BIT] = fired;
  end

  // Read data stands for one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: reg_rdata <= {{(DATA_W-$bits(tmds_ctrl_t)){1'b0}}, ctrl};
        REG_ON_DATE: reg_rdata <= pack_date(on_date);
        REG_OFF_DATE: reg_rdata <= pack_date(off_date);
        REG_STATUS: reg_rdata <= status_word;
        REG_CAL_DATE: reg_rdata <= pack_date(last_date);
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_pulse_set;
    scan_tick && ctrl.enable && ctrl.pulse && date_changed && pulse_hit && !fired;
  endsequence

  sequence s_pulse_drop;
    !switch_out;
  endsequence

  // A scan that sees the same day again ends any pulse
  sequence s_pulse_repeat;
    scan_tick && ctrl.pulse && !date_changed;
  endsequence

  a_midnight_only: assert property (
    $rose(switch_out) |-> $past(day_edge))
    else $error("output set away from a day boundary");

  a_monthly_on: assert property (
    scan_tick && day_edge && ctrl.enable && !ctrl.pulse && mode == MODE_MONTHLY
      |=> switch_out == $past(level_hit))
    else $error("monthly level not followed");

  a_yearly_on: assert property (
    scan_tick && day_edge && ctrl.enable && !ctrl.pulse && mode == MODE_YEARLY
      |=> switch_out == $past(level_hit))
    else $error("yearly level not followed");

  a_year_window: assert property (
    switch_out && !pending_eval && mode != MODE_SPAN
      |-> last_date.year >= on_date.year && last_date.year <= off_date.year)
    else $error("repeat output outside active years");

  a_pulse_width: assert property (
    s_pulse_repeat |=> s_pulse_drop)
    else $error("pulse held beyond one scan cycle");

  a_pulse_issue: assert property (
    s_pulse_set |=> switch_out)
    else $error("pulse not issued on the on date");

  a_pulse_combo: assert property (
    $rose(switch_out) && ctrl.pulse && mode == MODE_MONTHLY
      |-> last_date.day == on_date.day)
    else $error("monthly pulse on wrong day");

  a_span_hold: assert property (
    switch_out && !ctrl.pulse && mode == MODE_SPAN && !pending_eval
      |-> last_date >= on_date && last_date < off_date)
    else $error("span output outside on to off dates");

  a_no_late_on: assert property (
    $rose(switch_out) && !ctrl.pulse && mode == MODE_YEARLY
      && md_key(on_date) > md_key(off_date)
      |-> last_date.year < off_date.year || md_key(last_date) < md_key(off_date))
    else $error("yearly turn-on after final turn-off");

  a_yearly_pulse: assert property (
    $rose(switch_out) && ctrl.pulse && mode == MODE_YEARLY
      |-> md_key(last_date) == md_key(on_date) && last_date.year <= off_date.year)
    else $error("yearly pulse on wrong date");

  a_single_once: assert property (
    single_pulse && fired && $stable(fired) |-> !$rose(switch_out))
    else $error("single pulse fired twice");

  a_monthly_last: assert property (
    $rose(switch_out) && mode == MODE_MONTHLY |-> last_date.year <= off_date.year)
    else $error("monthly output beyond final year");

  a_scan_hold: assert property (
    !scan_tick && ctrl.enable |=> $stable(switch_out))
    else $error("output changed between scans");

  a_span_on: assert property (
    scan_tick && day_edge && ctrl.enable && !ctrl.pulse && mode == MODE_SPAN
      |=> switch_out == $past(level_hit))
    else $error("span level not followed");

  a_level_hold: assert property (
    scan_tick && !day_edge && ctrl.enable && !ctrl.pulse |=> $stable(switch_out))
    else $error("level changed within a day");

  a_disable_drop: assert property (
    !ctrl.enable |=> !switch_out)
    else $error("output high while disabled");

  a_eval_tracks: assert property (
    scan_tick |=> last_date == $past(cal_date))
    else $error("scan did not record the calendar date");

  a_pending_clear: assert property (
    scan_tick && !settings_wr |=> !pending_eval)
    else $error("evaluation request outlived its scan");

  a_fired_arm: assert property (
    scan_tick && ctrl.enable && single_pulse && date_changed && pulse_hit
      |=> fired)
    else $error("single pulse not marked as spent");

  a_single_quiet: assert property (
    single_pulse && fired && scan_tick |=> !switch_out)
    else $error("spent single pulse still drives the output");

  a_span_pulse: assert property (
    $rose(switch_out) && ctrl.pulse && mode == MODE_SPAN |-> last_date == on_date)
    else $error("single pulse away from the on date");

  a_reject_sticky: assert property (
    on_rej || off_rej |=> reject_flag)
    else $error("rejected date write not flagged");

  a_reject_clear: assert property (
    !on_rej && !off_rej && wr_status && reg_wdata[ST_REJECT_BIT]
      |=> !reject_flag)
    else $error("reject flag not cleared by software");

  a_cal_readback: assert property (
    reg_rd && reg_addr == REG_CAL_DATE
      |=> reg_rdata == pack_date($past(last_date)))
    else $error("evaluated date not read back");

  a_monthly_end: assert property (
    scan_tick && day_edge && mode == MODE_MONTHLY && cal_date.year > off_date.year
      |=> !switch_out)
    else $error("monthly output after the final year");

  a_yearly_end: assert property (
    scan_tick && day_edge && mode == MODE_YEARLY && cal_date.year > off_date.year
      |=> !switch_out)
    else $error("yearly output after the final year");

endmodule : tmds_switch

// file: tmds_cal_model.sv
// Calendar source partner: a scan tick every SCAN_PERIOD cycles and a date
// that moves only together with a tick. Assumes the bench supplies day_in.
`timescale 1ns/1ps
module tmds_cal_model import tmds_pkg::*; #(
  parameter int SCAN_PERIOD = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Date that takes effect with the next tick
  input tmds_date_t day_in,
  // Toward the switch
  output logic scan_tick,
  output tmds_date_t cal_date
);
  int cnt;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt <= 0;
      scan_tick <= 1'b0;
    end else begin
      cnt <= (cnt == SCAN_PERIOD - 1) ? 0 : cnt + 1;
      scan_tick <= (cnt == SCAN_PERIOD - 1);
    end
  end

  // The day rolls over only with a tick, so no scan sees a change mid-day
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cal_date <= ON_RESET;
    end else if (cnt == SCAN_PERIOD - 1) begin
      cal_date <= day_in;
    end
  end
endmodule : tmds_cal_model

// file: tmds_switch_tb_top.sv
// Self-checking bench for the twelve-month date switch.
// Assumes the calendar partner model and a 20 MHz reference clock.
`timescale 1ns/1ps
module tmds_switch_tb_top import tmds_pkg::*;;
  localparam int SCAN = 4;
  localparam int WIN = 3 * SCAN;
  logic ref_clk;
  logic reset;
  logic scan_tick;
  tmds_date_t cal_date;
  tmds_date_t day_in;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic switch_out;
  int error_cnt;
  int samples_checked;

  tmds_cal_model #(.SCAN_PERIOD(SCAN)) tmds_cal_model_inst (.ref_clk(ref_clk), .reset(reset),
    .day_in(day_in), .scan_tick(scan_tick), .cal_date(cal_date));
  tmds_switch tmds_switch_inst (.ref_clk(ref_clk), .reset(reset), .scan_tick(scan_tick),
    .cal_date(cal_date), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .switch_out(switch_out));

  initial begin
    ref_clk = 1'b0;
  end
  always #25 ref_clk = ~ref_clk;

  // Date word as software sees it: year, then month, then day
  function automatic logic [DATA_W-1:0] wd(input int y, input int m, input int d);
    logic [DATA_W-1:0] w;
    w = '0;
    w[27:16] = y[11:0];
    w[11:8] = m[3:0];
    w[4:0] = d[4:0];
    return w;
  endfunction : wd

  function automatic tmds_date_t dt(input int y, input int m, input int d);
    return {y[11:0], m[3:0], d[4:0]};
  endfunction : dt

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
  endtask : rd

  task automatic cfg(input logic [3:0] c, input logic [31:0] on_w, input logic [31:0] off_w);
    wr(REG_ON_DATE, on_w);
    wr(REG_OFF_DATE, off_w);
    wr(REG_CTRL, {28'h0, c});
  endtask : cfg

  // Moves the calendar to one day, then counts output-high cycles over three scans
  task automatic day(input int y, input int m, input int d, input int exp_hi);
    int hi;
    int k;
    int unk;
    hi = 0;
    k = 0;
    unk = 0;
    @(posedge ref_clk);
    day_in <= dt(y, m, d);
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (!(scan_tick === 1'b1 && cal_date === dt(y, m, d)) && k < 20);
    repeat (WIN) begin
      @(posedge ref_clk);
      #1;
      if (switch_out === 1'b1) hi++;
      else if (switch_out !== 1'b0) unk++;
    end
    chk("switch_out high cycles", 32'(hi), 32'(exp_hi));
    chk("switch_out unknown cycles", 32'(unk), 32'h0);
  endtask : day

  task automatic t_reset();
    rd(REG_CTRL, 32'h0);
    rd(REG_ON_DATE, wd(2000, 1, 1));
    rd(REG_OFF_DATE, wd(2099, 12, 31));
    rd(REG_STATUS, 32'h0);
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, 32'h0);
  endtask : t_reset

  task automatic t_range();
    logic [31:0] bad [3];
    bad = '{wd(1999, 6, 1), wd(2100, 6, 1), wd(2008, 13, 1)};
    foreach (bad[i]) begin
      wr(REG_ON_DATE, bad[i]);
      repeat (2) @(posedge ref_clk);
      rd(REG_ON_DATE, wd(2000, 1, 1));
      rd(REG_STATUS, 32'h2);
      wr(REG_STATUS, 32'h2);
      rd(REG_STATUS, 32'h0);
    end
    wr(REG_ON_DATE, wd(2099, 12, 30));
    repeat (2) @(posedge ref_clk);
    rd(REG_ON_DATE, wd(2099, 12, 30));
    rd(REG_STATUS, 32'h0);
  endtask : t_range

  task automatic t_span();
    cfg(4'h1, wd(2008, 6, 1), wd(2010, 8, 31));
    day(2008, 5, 31, 0);
    day(2008, 6, 1, WIN);
    day(2009, 12, 31, WIN);
    rd(REG_STATUS, 32'h1);
    wr(REG_CTRL, 32'h0);
    rd(REG_STATUS, 32'h0);
    wr(REG_CTRL, 32'h1);
    day(2010, 8, 30, WIN);
    day(2010, 8, 31, 0);
    rd(REG_CAL_DATE, wd(2010, 8, 31));
  endtask : t_span

  task automatic t_yearly();
    cfg(4'h5, wd(2008, 12, 15), wd(2010, 1, 7));
    day(2007, 12, 20, 0);
    day(2008, 12, 14, 0);
    day(2008, 12, 15, WIN);
    day(2009, 1, 6, WIN);
    day(2009, 1, 7, 0);
    day(2009, 12, 15, WIN);
    day(2010, 1, 7, 0);
    day(2010, 12, 15, 0);
  endtask : t_yearly

  task automatic t_monthly();
    cfg(4'h7, wd(2008, 0, 1), wd(2010, 0, 5));
    day(2007, 12, 2, 0);
    day(2008, 3, 1, WIN);
    day(2008, 3, 4, WIN);
    day(2008, 3, 5, 0);
    day(2010, 12, 1, WIN);
    day(2011, 1, 1, 0);
  endtask : t_monthly

  task automatic t_pulse();
    cfg(4'hd, wd(2008, 3, 15), wd(2010, 0, 0));
    day(2008, 3, 14, 0);
    day(2008, 3, 15, SCAN);
    day(2009, 3, 15, SCAN);
    day(2010, 3, 15, SCAN);
    day(2011, 3, 15, 0);
    cfg(4'hb, wd(2008, 0, 15), wd(2010, 0, 0));
    day(2008, 4, 15, SCAN);
    day(2008, 4, 16, 0);
    day(2008, 5, 15, SCAN);
    cfg(4'h9, wd(2008, 3, 15), wd(2010, 0, 0));
    day(2008, 3, 14, 0);
    day(2008, 3, 15, SCAN);
    rd(REG_STATUS, 32'h4);
    day(2008, 3, 16, 0);
    day(2008, 3, 15, 0);
    day(2009, 3, 15, 0);
  endtask : t_pulse

  initial begin
    error_cnt = 0;
    samples_checked = 0;
    reset = 1'b1;
    day_in = ON_RESET;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_range();
    t_span();
    t_yearly();
    t_monthly();
    t_pulse();
    report_and_stop();
  end

  // A run of some six hundred cycles is expected; twenty thousand means a hang
  initial begin
    #1000000;
    error_cnt++;
    report_and_stop();
  end
endmodule : tmds_switch_tb_top
